// >>> rtl/fsbp_pkg.sv
package fsbp_pkg;
    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 26;
    localparam int SECTOR_W = 10;
    localparam int SECTOR_LSB = 16;
    localparam int SUB32_LSB = 15;
    localparam int SUB4_LSB = 12;
    localparam logic [ADDR_W-1:0] TOP_ADDR = 26'h3FFFFFF;
    localparam logic [SECTOR_W-1:0] TOP_SECTOR = 10'h3FF;
    localparam logic [3:0] BP_ALL_MIN = 4'hB;

    // ------------------------------------------------------------
    // status register layout
    // ------------------------------------------------------------
    localparam int SR_LOCK_BIT = 7;
    localparam int SR_BP3_BIT = 6;
    localparam int SR_TB_BIT = 5;
    localparam int SR_BP_LO_MSB = 4;
    localparam int SR_BP_LO_LSB = 2;
    localparam int SR_WEL_BIT = 1;
    localparam int SR_WIP_BIT = 0;
    localparam logic [7:0] SR_NV_MASK = 8'hFC;
    localparam logic [7:0] SR_NV_RESET = 8'hA0;

    // flag status register bit positions
    localparam int FSR_READY_BIT = 7;
    localparam int FSR_ERASE_ERR_BIT = 5;
    localparam int FSR_PROG_ERR_BIT = 4;
    localparam int FSR_PROT_ERR_BIT = 1;

    // ------------------------------------------------------------
    // operation timing (busy cycles, shortened in simulation)
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int OP_TIME_NS = 400;
    localparam int OP_CYCLES = (OP_TIME_NS * CLK_MHZ) / 1000;

    typedef enum logic [2:0] {
        FSBP_OP_NONE,
        FSBP_OP_WREN,
        FSBP_OP_WRDI,
        FSBP_OP_WRSR,
        FSBP_OP_PROG,
        FSBP_OP_ERASE,
        FSBP_OP_BULK,
        FSBP_OP_CLRFS
    } fsbp_op_t;

    typedef enum logic [1:0] {
        FSBP_ER_64K,
        FSBP_ER_32K,
        FSBP_ER_4K
    } fsbp_esize_t;

    typedef struct packed {
        fsbp_op_t op;
        fsbp_esize_t esize;
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } fsbp_cmd_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] flag_status;
        logic busy;
        logic array_go;
        fsbp_op_t array_op;
    } fsbp_stat_t;
endpackage : fsbp_pkg

// >>> rtl/fsbp_range_decode.sv
`timescale 1ns/10ps
module fsbp_range_decode
    import fsbp_pkg::*;
(
    input wire logic [3:0] block_protect_bits,
    input wire logic top_bottom,
    input wire logic [SECTOR_W-1:0] sector,
    output logic protected_hit
);
    // ------------------------------------------------------------
    // range decode
    // ------------------------------------------------------------
    function automatic logic [SECTOR_W:0] fsbp_count(input logic [3:0] n);
        logic [SECTOR_W:0] c;
        c = '0;
        if (n >= BP_ALL_MIN) begin
            c = {1'b1, {SECTOR_W{1'b0}}};
        end else if (n != 4'h0) begin
            c = (SECTOR_W+1)'(1) << (n - 4'h1);
        end
        return c;
    endfunction : fsbp_count

    logic [SECTOR_W:0] cnt;
    logic [SECTOR_W:0] sec_ext;
    logic [SECTOR_W:0] from_top;

    always_comb begin
        cnt = fsbp_count(block_protect_bits);
        sec_ext = {1'b0, sector};
        from_top = {1'b0, TOP_SECTOR} - sec_ext;
        if (top_bottom) begin
            protected_hit = sec_ext < cnt;
        end else begin
            protected_hit = from_top < cnt;
        end
    end
endmodule : fsbp_range_decode

// >>> rtl/fsbp_busy_timer.sv
`timescale 1ns/10ps
module fsbp_busy_timer
    import fsbp_pkg::*;
#(
    parameter int CYCLES = OP_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start,
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic [15:0] cnt;
        logic busy;
    } fsbp_tmr_t;

    fsbp_tmr_t st;
    fsbp_tmr_t next_st;

    always_comb begin
        next_st = st;
        if (start && !st.busy) begin
            next_st.busy = 1'b1;
            next_st.cnt = 16'(CYCLES - 1);
        end else if (st.busy) begin
            if (st.cnt == 16'h0000) begin
                next_st.busy = 1'b0;
            end else begin
                next_st.cnt = st.cnt - 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign busy = st.busy;
    // done marks the last busy cycle, so the owner commits at the edge where
    // busy falls; a registered done would show ready before the commit
    assign done = st.busy && (st.cnt == 16'h0000);
endmodule : fsbp_busy_timer

// >>> rtl/fsbp_status_protect.sv
`timescale 1ns/10ps
// Overview of operation
// - 1024x64KB, 2048x32KB, 16384x4KB, linear addresses
// - pages programmable; no page erase
// - status register read and written by commands
// - lock bit and low pin freeze register
// - only raising write-protect pin releases lock
// - bit 7 lock, default one
// - bit 5 top/bottom select, default bottom
// - protect bits at 6 and 4:2
// - refuse program/erase in protected area
// - protect count 2^(N-1) sectors, 11+ all
// - write-enable latch clears at power-up
// - write-enable latch gates write/program/erase
// - bit 0 busy during write cycles
// - bit 0 inverse of flag ready bit
// - bulk erase only with protect bits zero
// - protection error sets flag bit 1
// - protected sectors guarded at either pin level
// - error flags cleared only by command or reset
module fsbp_status_protect
    import fsbp_pkg::*;
#(
    parameter int BUSY_CYCLES = OP_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire fsbp_cmd_t cmd,
    input wire logic write_protect_n,
    output fsbp_stat_t stat
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] nv;
        logic wel;
        logic erase_err;
        logic prog_err;
        logic prot_err;
        logic array_go;
        fsbp_op_t array_op;
        fsbp_op_t pend_op;
        logic [7:0] pend_sr;
    } fsbp_state_t;

    fsbp_state_t st;
    fsbp_state_t next_st;

    logic prot_hit;
    logic busy;
    logic done;
    logic start;
    logic hw_locked;
    logic [3:0] bp;

    assign bp = {st.nv[SR_BP3_BIT], st.nv[SR_BP_LO_MSB:SR_BP_LO_LSB]};

    // the address is split into sector index by the 64KB boundary, so any
    // 32KB or 4KB subsector inherits its parent sector's protection
    fsbp_range_decode u_decode (
        .block_protect_bits(bp),
        .top_bottom(st.nv[SR_TB_BIT]),
        .sector(cmd.addr[ADDR_W-1:SECTOR_LSB]),
        .protected_hit(prot_hit)
    );

    fsbp_busy_timer #(
        .CYCLES(BUSY_CYCLES)
    ) u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(start),
        .busy(busy),
        .done(done)
    );

    // lock holds only while the pin is low; raising it is the sole exit
    assign hw_locked = st.nv[SR_LOCK_BIT] && !write_protect_n;

    // ------------------------------------------------------------
    // command handling
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.array_go = 1'b0;
        start = 1'b0;
        if (done) begin
            if (st.pend_op == FSBP_OP_WRSR) begin
                next_st.nv = st.pend_sr & SR_NV_MASK;
            end
            next_st.wel = 1'b0;
            next_st.pend_op = FSBP_OP_NONE;
        end
        if (cmd_valid && !busy) begin
            case (cmd.op)
                FSBP_OP_WREN: begin
                    next_st.wel = 1'b1;
                end
                FSBP_OP_WRDI: begin
                    next_st.wel = 1'b0;
                end
                FSBP_OP_CLRFS: begin
                    next_st.erase_err = 1'b0;
                    next_st.prog_err = 1'b0;
                    next_st.prot_err = 1'b0;
                end
                FSBP_OP_WRSR: begin
                    if (st.wel && !hw_locked) begin
                        start = 1'b1;
                        next_st.pend_op = FSBP_OP_WRSR;
                        next_st.pend_sr = cmd.wdata;
                    end else begin
                        next_st.wel = 1'b0;
                    end
                end
                FSBP_OP_PROG, FSBP_OP_ERASE: begin
                    if (!st.wel) begin
                        next_st.wel = 1'b0;
                    end else if (prot_hit) begin
                        // refused: array untouched, error latched
                        next_st.prot_err = 1'b1;
                        if (cmd.op == FSBP_OP_PROG) begin
                            next_st.prog_err = 1'b1;
                        end else begin
                            next_st.erase_err = 1'b1;
                        end
                        next_st.wel = 1'b0;
                    end else begin
                        // page program allowed; erase only at sector sizes
                        start = 1'b1;
                        next_st.pend_op = cmd.op;
                        next_st.array_go = 1'b1;
                        next_st.array_op = cmd.op;
                    end
                end
                FSBP_OP_BULK: begin
                    if (st.wel && bp == 4'h0) begin
                        start = 1'b1;
                        next_st.pend_op = FSBP_OP_BULK;
                        next_st.array_go = 1'b1;
                        next_st.array_op = FSBP_OP_BULK;
                    end else begin
                        next_st.wel = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
            st.nv <= SR_NV_RESET;
            st.wel <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    always_comb begin
        stat = '0;
        stat.flag_status[FSR_READY_BIT] = !busy;
        stat.flag_status[FSR_ERASE_ERR_BIT] = st.erase_err;
        stat.flag_status[FSR_PROG_ERR_BIT] = st.prog_err;
        stat.flag_status[FSR_PROT_ERR_BIT] = st.prot_err;
        stat.status = st.nv & SR_NV_MASK;
        stat.status[SR_WEL_BIT] = st.wel;
        stat.status[SR_WIP_BIT] = !stat.flag_status[FSR_READY_BIT];
        stat.busy = busy;
        stat.array_go = st.array_go;
        stat.array_op = st.array_op;
    end
endmodule : fsbp_status_protect

// >>> verification/fsbp_host.sv
`timescale 1ns/10ps
module fsbp_host
    import fsbp_pkg::*;
(
    input wire logic core_clk,
    output logic cmd_valid,
    output fsbp_cmd_t cmd
);
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
    end
    task automatic send(input fsbp_op_t op, input fsbp_esize_t es,
                        input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b1;
        cmd = '{op, es, a, d};
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b0;
        // released bus shows the inverse so a stale value never looks valid
        cmd = ~cmd;
    endtask : send
endmodule : fsbp_host

// >>> verification/fsbp_status_protect_asserts.sv
`timescale 1ns/10ps
module fsbp_status_protect_asserts
    import fsbp_pkg::*;
#(
    parameter int BUSY_CYCLES = OP_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire fsbp_cmd_t cmd,
    input wire logic write_protect_n,
    input wire fsbp_stat_t stat
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic take;
    logic [3:0] bp;
    assign take = cmd_valid && !stat.busy;
    assign bp = {stat.status[6], stat.status[4:2]};
    chk_wip_ready: assert property (stat.status[0] == !stat.flag_status[7])
        else $error("busy bit not inverse of ready");
    chk_wren_set: assert property (take && cmd.op == FSBP_OP_WREN |=> stat.status[1])
        else $error("latch not set");
    chk_go_wel: assert property (stat.array_go |-> $past(stat.status[1]) ##1 !stat.array_go)
        else $error("array start without latch");
    logic [15:0] busy_run;
    always_ff @(posedge core_clk) begin
        if (!rst_n || !stat.busy) begin
            busy_run <= 16'h0000;
        end else begin
            busy_run <= busy_run + 16'h0001;
        end
    end
    chk_busy_len: assert property ($fell(stat.busy) |-> busy_run == 16'(BUSY_CYCLES))
        else $error("busy length wrong");
    chk_lock_hold: assert property (take && cmd.op == FSBP_OP_WRSR && stat.status[7]
        && !write_protect_n |=> !stat.busy && !stat.status[1]) else $error("locked write ran");
    chk_bulk_bp: assert property (take && cmd.op == FSBP_OP_BULK && bp != 4'h0
        |=> !stat.array_go && !stat.busy) else $error("bulk ran while protected");
    chk_prot_err: assert property (take && cmd.op == FSBP_OP_PROG && stat.status[1]
        && bp >= BP_ALL_MIN |=> stat.flag_status[1] && !stat.array_go) else $error("no refusal");
    chk_err_sticky: assert property (stat.flag_status[1]
        && !(take && cmd.op == FSBP_OP_CLRFS) |=> stat.flag_status[1]) else $error("flag lost");
    chk_wel_done: assert property ($fell(stat.busy) |-> !stat.status[1])
        else $error("latch kept after cycle");
    chk_nv_change: assert property ($changed(stat.status[7:2]) |-> $fell(stat.busy))
        else $error("protect bits changed outside a write");
endmodule : fsbp_status_protect_asserts
bind fsbp_status_protect fsbp_status_protect_asserts #(.BUSY_CYCLES(BUSY_CYCLES)) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .write_protect_n(write_protect_n), .stat(stat));

// >>> verification/fsbp_status_protect_tb.sv
`timescale 1ns/10ps
module fsbp_status_protect_tb;
    import fsbp_pkg::*;
    logic core_clk;
    logic rst_n;
    logic write_protect_n;
    logic cmd_valid;
    fsbp_cmd_t cmd;
    fsbp_stat_t stat;
    int errors;
    int n_tests;
    fsbp_host u_host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd(cmd));
    fsbp_status_protect #(.BUSY_CYCLES(4)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd(cmd), .write_protect_n(write_protect_n), .stat(stat));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic do_cmd(input fsbp_op_t op, input logic [ADDR_W-1:0] a = '0,
                          input logic [7:0] d = 8'h00);
        u_host.send(op, fsbp_esize_t'($urandom_range(2)), a, d);
    endtask : do_cmd
    task automatic wait_idle();
        repeat (20) begin
            if (stat.busy === 1'b0) return;
            @(posedge core_clk);
            #1;
        end
        errors++;
        end_sim();
    endtask : wait_idle
    task automatic write_sr(input logic [7:0] d);
        do_cmd(FSBP_OP_WREN);
        do_cmd(FSBP_OP_WRSR, '0, d);
        wait_idle();
    endtask : write_sr
    function automatic logic hit(input logic [3:0] n, input logic t, input logic [9:0] s);
        int c;
        c = (n == 0) ? 0 : (n > 10) ? 1024 : (1 << (n - 1));
        return t ? (s < c) : (s >= 1024 - c);
    endfunction : hit
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [3:0] n;
        logic t;
        logic e;
        logic [9:0] s;
        int bnd;
        errors = 0;
        n_tests = 0;
        rst_n = 1'b0;
        write_protect_n = 1'b0;
        void'($urandom(32'h78D05BE4));
        repeat (20) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        chk("status", stat.status, SR_NV_RESET);
        chk("flags", stat.flag_status, 8'h80);
        write_sr(8'h00);
        chk("status", stat.status, 8'hA0);
        write_protect_n = 1'b1;
        do_cmd(FSBP_OP_WREN);
        chk("wel", stat.status[1], 1'b1);
        do_cmd(FSBP_OP_WRDI);
        do_cmd(FSBP_OP_NONE);
        chk("wel", stat.status[1], 1'b0);
        $display("test reset and latch done");
        for (int k = 0; k < 48; k++) begin
            n = (k < 16) ? k[3:0] : 4'($urandom);
            t = 1'($urandom);
            write_sr({1'b0, n[3], t, n[2:0], 2'b00});
            chk("status", stat.status, {1'b0, n[3], t, n[2:0], 2'b00});
            bnd = (1 << n) >> 1;
            s = $urandom_range(1) ? 10'($urandom) :
                10'(t ? bnd - $urandom_range(1) : 1023 - bnd + $urandom_range(1));
            e = hit(n, t, s);
            do_cmd(FSBP_OP_WREN);
            do_cmd(k[0] ? FSBP_OP_PROG : FSBP_OP_ERASE, {s, 16'($urandom)});
            chk("go", stat.array_go, !e);
            chk("wip", stat.status[0], !e);
            chk("flags", stat.flag_status, e ? (k[0] ? 8'h92 : 8'hA2) : 8'h00);
            if (!e) begin
                chk("op", stat.array_op, k[0] ? FSBP_OP_PROG : FSBP_OP_ERASE);
            end
            chk("prot", stat.flag_status[1], e);
            wait_idle();
            chk("wel", stat.status[1], 1'b0);
            do_cmd(FSBP_OP_WREN);
            do_cmd(FSBP_OP_BULK);
            chk("bulk", stat.array_go, n == 4'h0);
            if (n == 4'h0) begin
                chk("op", stat.array_op, FSBP_OP_BULK);
            end
            wait_idle();
            chk("prot", stat.flag_status[1], e);
            do_cmd(FSBP_OP_CLRFS);
            chk("flags", stat.flag_status, 8'h80);
        end
        $display("test protect map done");
        write_sr(8'h84);
        write_protect_n = 1'b0;
        write_sr(8'h00);
        chk("status", stat.status, 8'h84);
        do_cmd(FSBP_OP_PROG, 26'h0);
        chk("go", stat.array_go, 1'b0);
        write_protect_n = 1'b1;
        write_sr(8'h00);
        chk("status", stat.status, 8'h00);
        $display("test lock pin done");
        do_cmd(FSBP_OP_WREN);
        chk("wel", stat.status[1], 1'b1);
        rst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        chk("status", stat.status, SR_NV_RESET);
        chk("flags", stat.flag_status, 8'h80);
        $display("test mid-run reset done");
        end_sim();
    end
endmodule : fsbp_status_protect_tb
